// >>> bench/gstc_ext_model.sv
// Far-side model: external count clock source and gate driver.
// Assumes the bench calls its tasks right after a rising edge of clk.
`timescale 1ns/1ns
module gstc_ext_model (
	// Clock
	input wire logic clk,
	// Pins
	output logic ext_count_clock,
	output logic gate_pin_n
);
	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Count clock idles low, so a low level always precedes the first rise; gate idles high
	initial begin
		ext_count_clock = 1'b0;
		gate_pin_n = 1'b1;
	end

	// Two clocks high, two low: slow enough for the synchroniser
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (2) @(posedge clk);
			ext_count_clock <= 1'b1;
			repeat (2) @(posedge clk);
			ext_count_clock <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask

	task automatic gate(input logic v);
		gate_pin_n <= v;
	endtask
endmodule // gstc_ext_model

// >>> bench/gstc_timer_tb.sv
// Testbench for the gated timer: register tests over Avalon-MM.
// Assumes one wait cycle per access and the partner model above.
`timescale 1ns/1ns
module gstc_timer_tb;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr_s = 1'b0, slp = 1'b0, iosc = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic wreq, ext_clk, gate_n, irq, wake, lpo;
	logic [7:0] q;
	int n_errors = 0, checks = 0;
	always #10 clk = ~clk;

	gstc_ext_model ext (.clk(clk), .ext_count_clock(ext_clk), .gate_pin_n(gate_n));
	gstc_timer dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
		.avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(4'hf),
		.avs_readdata(rdat), .avs_waitrequest(wreq), .ext_count_clock(ext_clk),
		.crystal_clock(1'b0), .gate_pin_n(gate_n), .sleep_mode(slp),
		.internal_oscillator(iosc), .irq_to_core(irq), .wake_request(wake),
		.lp_osc_on(lpo));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	function automatic logic [9:0] ad(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

	// Hold the request until a rising edge samples waitrequest low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int t;
		t = 0;
		adr <= ad(idx);
		wdat <= {24'h000000, d};
		rd <= !w;
		wr_s <= w;
		@(posedge clk);
		while (wreq !== 1'b0 && t < 100) begin
			@(posedge clk);
			t++;
		end
		if (wreq !== 1'b0) begin
			n_errors++;
			$display("[FAIL] %0t bus access timed out", $time);
		end
		q = rdat[7:0];
		rd <= 1'b0;
		wr_s <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
		checks++;
		if (!(g >= lo && g <= hi) || $isunknown(g)) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h..%h", $time, g, lo, hi);
		end
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [7:0] lo, input logic [7:0] hi);
		bus(1'b0, idx, 8'h00);
		chk(q, lo, hi);
	endtask

	task automatic setcnt(input logic [15:0] v);
		bus(1'b1, gstc_pkg::idx_count_low, v[7:0]);
		bus(1'b1, gstc_pkg::idx_count_high, v[15:8]);
	endtask

	task automatic ext_run(input logic [7:0] ctl, input int n, input logic [7:0] e);
		setcnt(16'h0000);
		bus(1'b1, gstc_pkg::idx_timer_control, ctl);
		ext.pulses(n);
		bus(1'b1, gstc_pkg::idx_timer_control, 8'h00);
		rchk(gstc_pkg::idx_count_low, e, e);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(gstc_pkg::idx_timer_control, 8'h00, 8'h00);
		rchk(gstc_pkg::idx_peripheral_flag, 8'h00, 8'h00);
		rchk(gstc_pkg::idx_peripheral_enable, 8'h00, 8'h00);
		bus(1'b1, gstc_pkg::idx_timer_control, 8'hff);
		rchk(gstc_pkg::idx_timer_control, 8'h7f, 8'h7f);
		rchk(8'hff, 8'h00, 8'h00);
		bus(1'b1, gstc_pkg::idx_timer_control, 8'h08);
		chk({7'h00, lpo}, 8'h00, 8'h00);
		iosc <= 1'b1;
		@(posedge clk);
		chk({7'h00, lpo}, 8'h01, 8'h01);
		repeat (50) @(posedge clk);
		$display("test registers done");
		for (int ps = 0; ps < 4; ps++) begin
			setcnt(16'h0000);
			bus(1'b1, gstc_pkg::idx_timer_control, {2'b00, ps[1:0], 4'h1});
			repeat (256) @(posedge clk);
			bus(1'b1, gstc_pkg::idx_timer_control, 8'h00);
			rchk(gstc_pkg::idx_count_low, (8'h40 >> ps) - 1, (8'h40 >> ps) + 2);
			repeat (20) @(posedge clk);
			rchk(gstc_pkg::idx_count_low, q, q);
		end
		$display("test prescale done");
		setcnt(16'hffff);
		bus(1'b1, gstc_pkg::idx_timer_control, 8'h01);
		repeat (20) @(posedge clk);
		bus(1'b1, gstc_pkg::idx_timer_control, 8'h00);
		rchk(gstc_pkg::idx_count_high, 8'h00, 8'h00);
		rchk(gstc_pkg::idx_peripheral_flag, 8'h01, 8'h01);
		bus(1'b1, gstc_pkg::idx_peripheral_enable, 8'h01);
		bus(1'b1, gstc_pkg::idx_core_irq_control, 8'h40);
		chk({6'h00, irq, wake}, 8'h00, 8'h00);
		bus(1'b1, gstc_pkg::idx_timer_control, 8'h01);
		chk({6'h00, irq, wake}, 8'h01, 8'h01);
		bus(1'b1, gstc_pkg::idx_core_irq_control, 8'hc0);
		chk({6'h00, irq, wake}, 8'h03, 8'h03);
		bus(1'b1, gstc_pkg::idx_peripheral_flag, 8'h00);
		chk({7'h00, irq}, 8'h00, 8'h00);
		bus(1'b1, gstc_pkg::idx_timer_control, 8'h00);
		bus(1'b1, gstc_pkg::idx_core_irq_control, 8'h00);
		$display("test overflow done");
		ext_run(8'h03, 3, 8'h03);
		ext_run(8'h07, 4, 8'h04);
		ext.gate(1'b1);
		ext_run(8'h43, 3, 8'h00);
		ext.gate(1'b0);
		ext_run(8'h43, 3, 8'h03);
		$display("test counter done");
		slp <= 1'b1;
		ext_run(8'h07, 3, 8'h03);
		ext_run(8'h03, 3, 8'h00);
		slp <= 1'b0;
		$display("test sleep done");
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule // gstc_timer_tb

// >>> rtl/gstc_pkg.sv
// Package for the gated sixteen-bit timer/counter.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address = 4 * index.
package gstc_pkg;
	// ----------------------------------------
	// Register indices and address width
	// ----------------------------------------
	localparam logic [7:0] idx_core_irq_control = 8'h0b;
	localparam logic [7:0] idx_peripheral_flag = 8'h0c;
	localparam logic [7:0] idx_count_low = 8'h0e;
	localparam logic [7:0] idx_count_high = 8'h0f;
	localparam logic [7:0] idx_timer_control = 8'h10;
	localparam logic [7:0] idx_peripheral_enable = 8'h8c;
	localparam int addr_w = 10;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int ctl_run = 0;
	localparam int ctl_source = 1;
	localparam int ctl_sync_dis = 2;
	localparam int ctl_lp_osc = 3;
	localparam int ctl_ps_lo = 4;
	localparam int ctl_gate_en = 6;
	localparam logic [7:0] ctl_mask = 8'h7f;
	localparam int flag_overflow = 0;
	localparam int ien_overflow = 0;
	localparam int core_global = 7;
	localparam int core_periph = 6;
	localparam logic [7:0] reg_reset = 8'h00;
	localparam logic [15:0] count_max = 16'hffff;
	localparam logic [1:0] instr_div_last = 2'h3;
	localparam logic [31:0] unmapped_read = 32'h00000000;

	typedef struct packed {
		logic gate_en;
		logic [1:0] prescale;
		logic lp_osc;
		logic sync_dis;
		logic source;
		logic run;
	} gstc_ctl_type;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_ack = 3'b010,
		st_done = 3'b100
	} gstc_bus_state_type;
endpackage

// >>> rtl/gstc_timer.sv
// Sixteen-bit gated timer/counter with Avalon-MM register access.
// Assumes ext_count_clock and gate_pin_n are synchronous to clk; unsync mode samples directly.
`timescale 1ns/1ns
module gstc_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [gstc_pkg::addr_w-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Pins and system status
	input wire logic ext_count_clock,
	input wire logic crystal_clock,
	input wire logic gate_pin_n,
	input wire logic sleep_mode,
	input wire logic internal_oscillator,
	// Core signals
	output logic irq_to_core,
	output logic wake_request,
	output logic lp_osc_on
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	gstc_pkg::gstc_ctl_type ctl_reg;
	logic [7:0] core_reg;
	logic overflow_flag_reg;
	logic overflow_irq_enable_reg;
	logic [15:0] count_reg;
	logic [2:0] presc_reg;
	logic [1:0] instr_div_reg;
	logic sync1_reg, sync2_reg, sync_prev_reg;
	logic raw_prev_reg;
	logic armed_reg;
	logic low_known_reg, high_known_reg;
	logic [31:0] rdata_reg;
	gstc_pkg::gstc_bus_state_type bus_state_reg, bus_state_next;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	function automatic logic hit(input logic [gstc_pkg::addr_w-1:0] a, input logic [7:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction
	wire logic [gstc_pkg::addr_w-1:0] a = avs_address;
	wire logic do_wr = avs_write && (bus_state_reg == gstc_pkg::st_ack) && avs_byteenable[0];
	wire logic do_rd = avs_read && (bus_state_reg == gstc_pkg::st_idle);
	wire logic wr_low = do_wr && hit(a, gstc_pkg::idx_count_low);
	wire logic wr_high = do_wr && hit(a, gstc_pkg::idx_count_high);
	wire logic wr_ctl = do_wr && hit(a, gstc_pkg::idx_timer_control);
	wire logic wr_core = do_wr && hit(a, gstc_pkg::idx_core_irq_control);
	wire logic wr_flag = do_wr && hit(a, gstc_pkg::idx_peripheral_flag);
	wire logic wr_ien = do_wr && hit(a, gstc_pkg::idx_peripheral_enable);
	wire logic [7:0] wbyte = avs_writedata[7:0];

	// One wait cycle for an access that starts in st_idle, two for one that starts in st_done; answer in st_ack
	always_comb begin
		bus_state_next = bus_state_reg;
		unique case (bus_state_reg)
			gstc_pkg::st_idle: if (avs_read || avs_write) bus_state_next = gstc_pkg::st_ack;
			gstc_pkg::st_ack: bus_state_next = gstc_pkg::st_done;
			gstc_pkg::st_done: bus_state_next = gstc_pkg::st_idle;
		endcase
	end
	assign avs_waitrequest = (avs_read || avs_write) && (bus_state_reg != gstc_pkg::st_ack);
	assign avs_readdata = rdata_reg;

	// ----------------------------------------
	// Clock source selection
	// ----------------------------------------
	// Crystal used only when the internal oscillator without clock output runs
	assign lp_osc_on = ctl_reg.lp_osc && internal_oscillator;
	wire logic ext_raw = lp_osc_on ? crystal_clock : ext_count_clock;
	wire logic async_mode = ctl_reg.source && ctl_reg.sync_dis;
	// Synchronised path stalls while the core clock sleeps
	wire logic sys_running = !sleep_mode || async_mode;
	wire logic sync_rise = sync2_reg && !sync_prev_reg;
	wire logic raw_rise = ext_raw && !raw_prev_reg;
	wire logic ext_rise = ctl_reg.sync_dis ? raw_rise : sync_rise;
	wire logic ext_level = ctl_reg.sync_dis ? ext_raw : sync2_reg;
	wire logic instr_tick = (instr_div_reg == gstc_pkg::instr_div_last);
	wire logic src_tick = ctl_reg.source ? (ext_rise && armed_reg) : instr_tick;
	wire logic gate_ok = !ctl_reg.gate_en || !gate_pin_n;
	wire logic count_en = ctl_reg.run && gate_ok && sys_running;

	// ----------------------------------------
	// Prescaler and count
	// ----------------------------------------
	wire logic [2:0] presc_last = 3'((1 << ctl_reg.prescale) - 1);
	wire logic presc_tick = count_en && src_tick && (presc_reg == presc_last);
	wire logic rollover = presc_tick && (count_reg == gstc_pkg::count_max);

	always_ff @(posedge clk) begin
		if (rst) begin
			instr_div_reg <= 2'h0;
			presc_reg <= 3'h0;
		end else begin
			instr_div_reg <= 2'(instr_div_reg + 2'h1);
			if (wr_low || wr_high) begin
				presc_reg <= 3'h0;
			end else if (count_en && src_tick) begin
				presc_reg <= presc_tick ? 3'h0 : 3'(presc_reg + 3'h1);
			end
		end
	end

	// Count has no reset; software write wins over an increment
	always_ff @(posedge clk) begin
		if (wr_low) begin
			count_reg[7:0] <= wbyte;
		end else if (wr_high) begin
			count_reg[15:8] <= wbyte;
		end else if (presc_tick) begin
			count_reg <= 16'(count_reg + 16'h1);
		end
	end

	// External edge tracking; arming needs a low level first
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync_prev_reg <= 1'b0;
			raw_prev_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			if (sys_running) begin
				sync1_reg <= ext_raw;
				sync2_reg <= sync1_reg;
				sync_prev_reg <= sync2_reg;
			end
			raw_prev_reg <= ext_raw;
			if (wr_ctl) begin
				armed_reg <= 1'b0;
			end else if (!ext_level && sys_running) begin
				armed_reg <= 1'b1;
			end
		end
	end

	// Count has no reset, so checks on it wait until both bytes were written
	always_ff @(posedge clk) begin
		if (rst) begin
			low_known_reg <= 1'b0;
			high_known_reg <= 1'b0;
		end else begin
			if (wr_low) low_known_reg <= 1'b1;
			if (wr_high) high_known_reg <= 1'b1;
		end
	end
	wire logic count_known = low_known_reg && high_known_reg;

	// ----------------------------------------
	// Control and interrupt registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_reg <= gstc_pkg::reg_reset[6:0];
			core_reg <= gstc_pkg::reg_reset;
			overflow_flag_reg <= 1'b0;
			overflow_irq_enable_reg <= 1'b0;
		end else begin
			if (wr_ctl) ctl_reg <= wbyte[6:0];
			if (wr_core) core_reg <= wbyte;
			if (wr_ien) overflow_irq_enable_reg <= wbyte[gstc_pkg::ien_overflow];
			// Set wins over a clear in the same cycle
			if (rollover) begin
				overflow_flag_reg <= 1'b1;
			end else if (wr_flag) begin
				overflow_flag_reg <= wbyte[gstc_pkg::flag_overflow];
			end
		end
	end

	wire logic irq_armed = overflow_flag_reg && overflow_irq_enable_reg
		&& core_reg[gstc_pkg::core_periph];
	assign irq_to_core = irq_armed && core_reg[gstc_pkg::core_global];
	assign wake_request = irq_armed && ctl_reg.run;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Count sampled on the clk edge; each byte is read in its own access, so the pair can tear
	wire logic [7:0] rd_byte =
		hit(a, gstc_pkg::idx_count_low) ? count_reg[7:0] :
		hit(a, gstc_pkg::idx_count_high) ? count_reg[15:8] :
		hit(a, gstc_pkg::idx_timer_control) ? {1'b0, ctl_reg} :
		hit(a, gstc_pkg::idx_core_irq_control) ? core_reg :
		hit(a, gstc_pkg::idx_peripheral_flag) ? {7'h00, overflow_flag_reg} :
		hit(a, gstc_pkg::idx_peripheral_enable) ? {7'h00, overflow_irq_enable_reg} :
		gstc_pkg::unmapped_read[7:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_state_reg <= gstc_pkg::st_idle;
			rdata_reg <= gstc_pkg::unmapped_read;
		end else begin
			bus_state_reg <= bus_state_next;
			if (do_rd) rdata_reg <= {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_roll_to_zero: assert property (@(posedge clk) disable iff (rst)
		rollover && count_known && !wr_low && !wr_high
		|=> count_reg == 16'h0000 && overflow_flag_reg)
		else $error("count did not roll over to zero with flag");
	chk_hold_stopped: assert property (@(posedge clk) disable iff (rst)
		!ctl_reg.run && count_known && !wr_low && !wr_high |=> $stable(count_reg))
		else $error("count changed while stopped");
	chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		overflow_flag_reg && !wr_flag |=> overflow_flag_reg)
		else $error("overflow flag cleared by hardware");
	chk_irq_gating: assert property (@(posedge clk) disable iff (rst)
		irq_to_core |-> overflow_irq_enable_reg && core_reg[gstc_pkg::core_periph]
		&& core_reg[gstc_pkg::core_global])
		else $error("interrupt raised without all enables");
	chk_presc_clear: assert property (@(posedge clk) disable iff (rst)
		wr_low || wr_high |=> presc_reg == 3'h0)
		else $error("prescaler not cleared by count write");
	chk_gate_block: assert property (@(posedge clk) disable iff (rst)
		ctl_reg.gate_en && gate_pin_n && count_known && !wr_low && !wr_high
		|=> $stable(count_reg))
		else $error("count advanced while gated off");
	chk_instr_rate: assert property (@(posedge clk) disable iff (rst)
		count_en && !ctl_reg.source && ctl_reg.prescale == 2'h0 && instr_tick
		&& count_known && !wr_low && !wr_high |=> count_reg == 16'($past(count_reg) + 16'h1))
		else $error("timer missed an instruction tick");
	chk_ctl_top_zero: assert property (@(posedge clk) disable iff (rst)
		do_rd && hit(a, gstc_pkg::idx_timer_control) |=> rdata_reg[7] == 1'b0)
		else $error("control bit 7 read as one");
	chk_arm_first: assert property (@(posedge clk) disable iff (rst)
		wr_ctl |=> !armed_reg)
		else $error("edge arming not cleared on setup");
	chk_sleep_sync: assert property (@(posedge clk) disable iff (rst)
		sleep_mode && !async_mode && count_known && !wr_low && !wr_high
		|=> $stable(count_reg))
		else $error("synchronised count ran in sleep");
	chk_tick_adds_one: assert property (@(posedge clk) disable iff (rst)
		presc_tick && count_known && !wr_low && !wr_high
		|=> count_reg == 16'($past(count_reg) + 16'h1))
		else $error("count did not advance by one on a tick");
	chk_flag_set: assert property (@(posedge clk) disable iff (rst)
		rollover |=> overflow_flag_reg)
		else $error("rollover did not set the flag");
	chk_unarmed_still: assert property (@(posedge clk) disable iff (rst)
		ctl_reg.source && !armed_reg |-> !src_tick)
		else $error("counted an edge before arming");
	chk_int_source: assert property (@(posedge clk) disable iff (rst)
		!ctl_reg.source |-> src_tick == instr_tick)
		else $error("internal source not on instruction tick");
	chk_ext_source: assert property (@(posedge clk) disable iff (rst)
		ctl_reg.source && src_tick |-> ext_rise)
		else $error("external count without a rising edge");
	chk_lp_osc_gate: assert property (@(posedge clk) disable iff (rst)
		lp_osc_on |-> internal_oscillator && ctl_reg.lp_osc)
		else $error("crystal enabled without internal oscillator");
	chk_wake_needs: assert property (@(posedge clk) disable iff (rst)
		wake_request |-> ctl_reg.run && overflow_irq_enable_reg
		&& core_reg[gstc_pkg::core_periph] && overflow_flag_reg)
		else $error("wake raised without all enables");
	chk_wake_on_flag: assert property (@(posedge clk) disable iff (rst)
		overflow_flag_reg && ctl_reg.run && overflow_irq_enable_reg
		&& core_reg[gstc_pkg::core_periph] |-> wake_request)
		else $error("wake missing on enabled overflow");
	chk_irq_on_flag: assert property (@(posedge clk) disable iff (rst)
		overflow_flag_reg && overflow_irq_enable_reg && core_reg[gstc_pkg::core_periph]
		&& core_reg[gstc_pkg::core_global] |-> irq_to_core)
		else $error("interrupt missing with all enables set");
	chk_off_no_count: assert property (@(posedge clk) disable iff (rst)
		!ctl_reg.run |-> !count_en)
		else $error("count enabled while timer off");
	chk_gate_open: assert property (@(posedge clk) disable iff (rst)
		ctl_reg.run && !ctl_reg.gate_en && sys_running |-> count_en)
		else $error("ungated timer not enabled");
	chk_async_sleep: assert property (@(posedge clk) disable iff (rst)
		sleep_mode && async_mode && ctl_reg.run && gate_ok |-> count_en)
		else $error("asynchronous counter stopped in sleep");
	chk_low_write: assert property (@(posedge clk) disable iff (rst)
		wr_low |=> count_reg[7:0] == $past(wbyte))
		else $error("low count byte not written");
	chk_high_write: assert property (@(posedge clk) disable iff (rst)
		wr_high |=> count_reg[15:8] == $past(wbyte))
		else $error("high count byte not written");
	chk_ctl_write: assert property (@(posedge clk) disable iff (rst)
		wr_ctl |=> ctl_reg == $past(wbyte[6:0]))
		else $error("control write not stored");
	chk_flag_write: assert property (@(posedge clk) disable iff (rst)
		wr_flag && !rollover |=> overflow_flag_reg == $past(wbyte[gstc_pkg::flag_overflow]))
		else $error("flag write not stored");
	chk_read_top_zero: assert property (@(posedge clk) disable iff (rst)
		rdata_reg[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	chk_wait_first: assert property (@(posedge clk) disable iff (rst)
		(avs_read || avs_write) && bus_state_reg == gstc_pkg::st_idle |-> avs_waitrequest)
		else $error("no wait cycle on a new request");
	chk_answer_next: assert property (@(posedge clk) disable iff (rst)
		bus_state_reg == gstc_pkg::st_idle && (avs_read || avs_write)
		|=> bus_state_reg == gstc_pkg::st_ack)
		else $error("request not answered in next cycle");
	chk_idle_no_wait: assert property (@(posedge clk) disable iff (rst)
		!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("waitrequest raised with no request");
	chk_async_direct: assert property (@(posedge clk) disable iff (rst)
		ctl_reg.source && ctl_reg.sync_dis |-> ext_rise == raw_rise)
		else $error("unsynchronised mode used the synchroniser");
	chk_sync_path: assert property (@(posedge clk) disable iff (rst)
		ctl_reg.source && !ctl_reg.sync_dis |-> ext_rise == sync_rise)
		else $error("synchronised mode bypassed the synchroniser");
endmodule // gstc_timer
